// File: common/rbx_pkg.sv
// Package for the relative branch execution block: opcodes, phases, widths.
// Assumes a core that feeds one instruction word per instruction cycle.
package rbx_pkg;

  // Widths
  localparam int PC_W = 21;

  // Opcode patterns and masks
  localparam logic [15:0] OPC_BNOFL_MASK = 16'hFF00;
  localparam logic [15:0] OPC_BNOFL_VAL  = 16'hE500;
  localparam logic [15:0] OPC_BNZERO_VAL = 16'hE100;
  localparam logic [15:0] OPC_BALW_MASK  = 16'hF800;
  localparam logic [15:0] OPC_BALW_VAL   = 16'hD000;

  // Field positions
  localparam int OFS8_MSB  = 7;
  localparam int OFS11_MSB = 10;

  // Target step: offset counted in words of two bytes
  localparam int WORD_SHIFT = 1;

  // Reset values
  localparam logic [20:0] PC_RST = 21'h000000;

  // Quarter phases, Gray coded along Q1..Q4
  typedef enum logic [1:0] {
    RBX_Q1 = 2'b00,
    RBX_Q2 = 2'b01,
    RBX_Q3 = 2'b11,
    RBX_Q4 = 2'b10
  } rbx_phase_t;

  // Instruction cycle kind
  typedef enum logic [1:0] {
    RBX_OP_NONE   = 2'b00,
    RBX_OP_BNOFL  = 2'b01,
    RBX_OP_BNZERO = 2'b11,
    RBX_OP_BALW   = 2'b10
  } rbx_op_t;

  // Status flags from the ALU
  typedef struct packed {
    logic ovf;
    logic zero;
  } rbx_flags_t;

  // Result towards the program counter unit
  typedef struct packed {
    logic        pc_we;
    logic [20:0] pc_val;
  } rbx_pcw_t;

endpackage : rbx_pkg

// File: hdl/rbx_decode.sv
// Opcode decoder for the three relative branches.
// Assumes a full 16-bit instruction word at its input.
`timescale 1ns/100ps
module rbx_decode (
  input  wire logic [15:0]     instr_i,   // Instruction word
  output rbx_pkg::rbx_op_t     op_o,      // Decoded branch kind
  output logic [20:0]          disp_o     // Byte displacement 2n
);

  logic signed [20:0] n_ext;

  // Match opcodes and sign-extend offset
  always_comb
  begin
    op_o  = rbx_pkg::RBX_OP_NONE;
    n_ext = '0;
    if ((instr_i & rbx_pkg::OPC_BNOFL_MASK) == rbx_pkg::OPC_BNOFL_VAL)
    begin
      op_o  = rbx_pkg::RBX_OP_BNOFL;
      n_ext = 21'(signed'(instr_i[rbx_pkg::OFS8_MSB:0]));
    end
    else if ((instr_i & rbx_pkg::OPC_BNOFL_MASK) == rbx_pkg::OPC_BNZERO_VAL)
    begin
      op_o  = rbx_pkg::RBX_OP_BNZERO;
      n_ext = 21'(signed'(instr_i[rbx_pkg::OFS8_MSB:0]));
    end
    else if ((instr_i & rbx_pkg::OPC_BALW_MASK) == rbx_pkg::OPC_BALW_VAL)
    begin
      op_o  = rbx_pkg::RBX_OP_BALW;
      n_ext = 21'(signed'(instr_i[rbx_pkg::OFS11_MSB:0]));
    end
    disp_o = n_ext <<< rbx_pkg::WORD_SHIFT;
  end

endmodule : rbx_decode

// File: hdl/rbx_exec.sv
// Relative branch executor: phase sequencer, condition test, PC write.
// Assumes instr_i valid from Q1 and pc_i already incremented past the branch.
`timescale 1ns/100ps
// Summary of operation
// - Opcode E5nn branches when overflow flag is zero.
// - Opcode E1nn branches when zero flag is zero.
// - Opcode D0nn-D7nn with 11-bit offset always branches.
// - Conditional offset is signed 8-bit, doubled before addition.
// - Target equals incremented PC plus twice the sign-extended offset.
// - Conditional: one cycle not taken, two cycles taken with a nop.
// - Unconditional branch always takes two cycles, second is a nop.
// - Taken branch writes the PC in phase Q4 of cycle one.
// - Not-taken branch writes nothing in Q4, PC stays incremented.
module rbx_exec (
  input  wire logic                mclk_i,    // Core clock, 100 MHz
  input  wire logic                rst_i,     // Sync reset, active high
  input  wire logic [15:0]         instr_i,   // Current instruction word
  input  wire logic [20:0]         pc_i,      // Incremented program counter
  input  wire rbx_pkg::rbx_flags_t flags_i,   // ALU status flags
  output rbx_pkg::rbx_phase_t      phase_o,   // Current quarter phase
  output logic                     flush_o,   // Nop cycle, prefetch dropped
  output logic                     cyc_end_o, // Last Q4 of an instruction
  output rbx_pkg::rbx_pcw_t        pcw_o      // PC write request
);

  // Whole state of the block
  typedef struct packed {
    rbx_pkg::rbx_phase_t phase;
    rbx_pkg::rbx_op_t    op;
    logic [20:0]         disp;
    logic                take;
    logic                nop_cyc;
    logic [1:0]          ncyc;
    rbx_pkg::rbx_pcw_t   pcw;
  } rbx_state_t;

  rbx_state_t       st_ff;
  rbx_state_t       nxt_st;
  rbx_pkg::rbx_op_t dec_op;
  logic [20:0]      dec_disp;

  rbx_decode u_decode (
    .instr_i (instr_i),
    .op_o    (dec_op),
    .disp_o  (dec_disp)
  );

  // Condition test on flags as they stand now
  function automatic logic cond_ok(input rbx_pkg::rbx_op_t op,
                                   input rbx_pkg::rbx_flags_t fl);
    case (op)
      rbx_pkg::RBX_OP_BNOFL:  cond_ok = !fl.ovf;
      rbx_pkg::RBX_OP_BNZERO: cond_ok = !fl.zero;
      rbx_pkg::RBX_OP_BALW:   cond_ok = 1'b1;
      default:                cond_ok = 1'b0;
    endcase
  endfunction : cond_ok

  // Phase sequencer and branch execution
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.pcw.pc_we = 1'b0;
    case (st_ff.phase)
      rbx_pkg::RBX_Q1:
      begin
        nxt_st.phase = rbx_pkg::RBX_Q2;
        if (!st_ff.nop_cyc)
          nxt_st.op = dec_op;
        else
          nxt_st.op = rbx_pkg::RBX_OP_NONE;
      end
      rbx_pkg::RBX_Q2:
      begin
        nxt_st.phase = rbx_pkg::RBX_Q3;
        nxt_st.disp  = dec_disp;
      end
      rbx_pkg::RBX_Q3:
      begin
        nxt_st.phase = rbx_pkg::RBX_Q4;
        nxt_st.take  = cond_ok(st_ff.op, flags_i);
        if (cond_ok(st_ff.op, flags_i))
        begin
          nxt_st.pcw.pc_we  = 1'b1;
          nxt_st.pcw.pc_val = pc_i + st_ff.disp;
        end
      end
      rbx_pkg::RBX_Q4:
      begin
        nxt_st.phase   = rbx_pkg::RBX_Q1;
        nxt_st.nop_cyc = st_ff.take && !st_ff.nop_cyc;
        nxt_st.take    = 1'b0;
        nxt_st.ncyc    = st_ff.take ? st_ff.ncyc + 2'h1 : 2'h0;
      end
      default: nxt_st.phase = rbx_pkg::RBX_Q1;
    endcase
  end

  // State register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      st_ff            <= '0;
      st_ff.phase      <= rbx_pkg::RBX_Q1;
      st_ff.pcw.pc_val <= rbx_pkg::PC_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs
  assign phase_o   = st_ff.phase;
  assign flush_o   = st_ff.nop_cyc;
  assign pcw_o     = st_ff.pcw;
  assign cyc_end_o = (st_ff.phase == rbx_pkg::RBX_Q4) && !st_ff.take;

  // Checks on condition, target, phases and cycle count

  property p_bnofl_taken;
    @(posedge mclk_i) disable iff (rst_i)
    (st_ff.phase == rbx_pkg::RBX_Q3 && st_ff.op == rbx_pkg::RBX_OP_BNOFL && !flags_i.ovf)
      |=> pcw_o.pc_we && pcw_o.pc_val == $past(pc_i) + $past(st_ff.disp);
  endproperty
  a_bnofl_taken: assert property (p_bnofl_taken)
    else $error("overflow-clear branch lost");

  property p_bnzero_block;
    @(posedge mclk_i) disable iff (rst_i)
    (st_ff.phase == rbx_pkg::RBX_Q3 && st_ff.op == rbx_pkg::RBX_OP_BNZERO && flags_i.zero)
      |=> !pcw_o.pc_we;
  endproperty
  a_bnzero_block: assert property (p_bnzero_block)
    else $error("nonzero branch taken on zero");

  property p_balw;
    @(posedge mclk_i) disable iff (rst_i)
    (st_ff.phase == rbx_pkg::RBX_Q3 && st_ff.op == rbx_pkg::RBX_OP_BALW) |=> pcw_o.pc_we;
  endproperty
  a_balw: assert property (p_balw) else $error("always branch not taken");

  property p_disp_even;
    @(posedge mclk_i) disable iff (rst_i)
    pcw_o.pc_we |-> $past(st_ff.disp[0]) == 1'b0;
  endproperty
  a_disp_even: assert property (p_disp_even) else $error("odd displacement");

  property p_we_q4;
    @(posedge mclk_i) disable iff (rst_i)
    pcw_o.pc_we |-> st_ff.phase == rbx_pkg::RBX_Q4 && !flush_o;
  endproperty
  a_we_q4: assert property (p_we_q4) else $error("PC write outside Q4");

  property p_nop_follows;
    @(posedge mclk_i) disable iff (rst_i)
    pcw_o.pc_we |=> flush_o [*4] ##1 !flush_o;
  endproperty
  a_nop_follows: assert property (p_nop_follows) else $error("no single nop cycle");

  property p_two_cycles;
    @(posedge mclk_i) disable iff (rst_i)
    cyc_end_o |-> st_ff.ncyc <= 2'h1;
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("branch too long");

  property p_no_write_untaken;
    @(posedge mclk_i) disable iff (rst_i)
    (st_ff.phase == rbx_pkg::RBX_Q4 && !st_ff.take) |-> !pcw_o.pc_we;
  endproperty
  a_no_write_untaken: assert property (p_no_write_untaken) else $error("untaken write");

  property p_phase_walk;
    @(posedge mclk_i) disable iff (rst_i)
    phase_o == rbx_pkg::RBX_Q1 |=> phase_o == rbx_pkg::RBX_Q2 ##1 phase_o == rbx_pkg::RBX_Q3;
  endproperty
  a_phase_walk: assert property (p_phase_walk) else $error("phase order broken");

  property p_bnofl_block;
    @(posedge mclk_i) disable iff (rst_i)
    (st_ff.phase == rbx_pkg::RBX_Q3 && st_ff.op == rbx_pkg::RBX_OP_BNOFL && flags_i.ovf)
      |=> !pcw_o.pc_we;
  endproperty
  a_bnofl_block: assert property (p_bnofl_block)
    else $error("overflow-clear branch taken on overflow");

  property p_bnzero_taken;
    @(posedge mclk_i) disable iff (rst_i)
    (st_ff.phase == rbx_pkg::RBX_Q3 && st_ff.op == rbx_pkg::RBX_OP_BNZERO && !flags_i.zero)
      |=> pcw_o.pc_we;
  endproperty
  a_bnzero_taken: assert property (p_bnzero_taken)
    else $error("nonzero branch lost");

  property p_target;
    @(posedge mclk_i) disable iff (rst_i)
    pcw_o.pc_we |-> pcw_o.pc_val == $past(pc_i) + $past(st_ff.disp);
  endproperty
  a_target: assert property (p_target)
    else $error("branch target wrong");

  property p_disp_range;
    @(posedge mclk_i) disable iff (rst_i)
    (st_ff.phase == rbx_pkg::RBX_Q3 &&
     (st_ff.op == rbx_pkg::RBX_OP_BNOFL || st_ff.op == rbx_pkg::RBX_OP_BNZERO))
      |-> st_ff.disp[20:9] == {12{st_ff.disp[8]}} && !st_ff.disp[0];
  endproperty
  a_disp_range: assert property (p_disp_range)
    else $error("conditional offset out of range");

  property p_nop_idle;
    @(posedge mclk_i) disable iff (rst_i)
    (flush_o && phase_o != rbx_pkg::RBX_Q1) |-> st_ff.op == rbx_pkg::RBX_OP_NONE;
  endproperty
  a_nop_idle: assert property (p_nop_idle)
    else $error("instruction decoded in nop cycle");

  property p_val_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !pcw_o.pc_we |-> $stable(pcw_o.pc_val);
  endproperty
  a_val_hold: assert property (p_val_hold)
    else $error("target changed without write");

  c_taken:   cover property (@(posedge mclk_i) disable iff (rst_i) pcw_o.pc_we);
  c_untaken: cover property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.phase == rbx_pkg::RBX_Q4 && st_ff.op != rbx_pkg::RBX_OP_NONE && !st_ff.take);
  c_balw:    cover property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.op == rbx_pkg::RBX_OP_BALW && pcw_o.pc_we);
  c_bnzero:  cover property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.op == rbx_pkg::RBX_OP_BNZERO && pcw_o.pc_we);
  c_nop_skip: cover property (@(posedge mclk_i) disable iff (rst_i)
    flush_o && phase_o == rbx_pkg::RBX_Q1 && dec_op != rbx_pkg::RBX_OP_NONE);

endmodule : rbx_exec

// File: dv/tb.sv
// Self-checking bench for the relative branch executor.
// Assumes rbx_exec decodes internally and its phase counter starts at Q1 after reset.
`timescale 1ns/100ps
module tb;
  logic                mclk_i;
  logic                rst_i;
  logic [15:0]         instr_i;
  logic [20:0]         pc_i;
  rbx_pkg::rbx_flags_t flags_i;
  rbx_pkg::rbx_phase_t phase_o;
  logic                flush_o;
  logic                cyc_end_o;
  rbx_pkg::rbx_pcw_t   pcw_o;
  int                  fail_count;
  int                  checked;
  int                  cyc = 0;
  logic [20:0]         last;

  rbx_exec rbx_exec_i (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .instr_i  (instr_i),
    .pc_i     (pc_i),
    .flags_i  (flags_i),
    .phase_o  (phase_o),
    .flush_o  (flush_o),
    .cyc_end_o(cyc_end_o),
    .pcw_o    (pcw_o)
  );

  // Clock, 10 ns period
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Verdict and end of run
  task automatic stop_test;
    $display("fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Compare one value
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Expected target: incremented PC plus twice the signed offset
  function automatic logic [20:0] tgt(input logic [20:0] pc, input logic [15:0] ins);
    if (ins[15:11] == 5'h1A)
      return pc + {{9{ins[10]}}, ins[10:0], 1'b0};
    return pc + {{12{ins[7]}}, ins[7:0], 1'b0};
  endfunction : tgt

  // One instruction; flags f1 from Q1, f2 from Q3 (ovf is the upper bit)
  task automatic run(input logic [15:0] ins, input logic [1:0] f1, input logic [1:0] f2,
                     input logic [20:0] pc, input logic tk);
    int i;
    i = 0;
    while (phase_o !== rbx_pkg::RBX_Q4 && i < 8)
    begin
      @(negedge mclk_i);
      i++;
    end
    @(posedge mclk_i);
    instr_i <= ins;
    pc_i    <= pc;
    flags_i <= f1;
    @(negedge mclk_i);
    chk(21'(phase_o), 21'(rbx_pkg::RBX_Q1));
    repeat (2) @(posedge mclk_i);
    flags_i <= f2;
    repeat (2) @(negedge mclk_i);
    chk(21'(phase_o), 21'(rbx_pkg::RBX_Q4));
    chk(21'(pcw_o.pc_we), 21'(tk));
    chk(21'(cyc_end_o), 21'(!tk));
    if (tk)
      last = tgt(pc, ins);
    chk(pcw_o.pc_val, last);
    if (tk)
    begin
      // A branch offered during the nop cycle must be ignored
      @(posedge mclk_i);
      instr_i <= 16'hE500;
      flags_i <= 2'b00;
      for (i = 0; i < 4; i++)
      begin
        @(negedge mclk_i);
        chk(21'(flush_o), 21'h000001);
        chk(21'(pcw_o.pc_we), 21'h000000);
      end
      chk(21'(cyc_end_o), 21'h000001);
    end
    else
      chk(21'(flush_o), 21'h000000);
  endtask : run

  // Branch when overflow clear, offsets at both ends
  task automatic t_bnofl;
    run(16'hE505, 2'b00, 2'b00, 21'h001000, 1'b1);
    run(16'hE505, 2'b10, 2'b10, 21'h001000, 1'b0);
    run(16'hE580, 2'b01, 2'b01, 21'h000100, 1'b1);
    run(16'hE57F, 2'b00, 2'b00, 21'h000100, 1'b1);
  endtask : t_bnofl

  // Branch when zero clear, overflow ignored, PC wrap
  task automatic t_bnzero;
    run(16'hE103, 2'b10, 2'b10, 21'h002000, 1'b1);
    run(16'hE103, 2'b01, 2'b01, 21'h002000, 1'b0);
    run(16'hE1FF, 2'b00, 2'b00, 21'h000000, 1'b1);
  endtask : t_bnzero

  // Unconditional branch, 11-bit offset limits, flags set
  task automatic t_balw;
    run(16'hD3FF, 2'b11, 2'b11, 21'h004000, 1'b1);
    run(16'hD400, 2'b11, 2'b11, 21'h000800, 1'b1);
    run(16'hD7FF, 2'b00, 2'b00, 21'h000010, 1'b1);
  endtask : t_balw

  // Flags taken as they stand in the process phase
  task automatic t_late;
    run(16'hE505, 2'b10, 2'b00, 21'h003000, 1'b1);
    run(16'hE101, 2'b00, 2'b01, 21'h003000, 1'b0);
  endtask : t_late

  // Neighbouring opcodes do nothing
  task automatic t_other;
    run(16'hE200, 2'b00, 2'b00, 21'h005000, 1'b0);
    run(16'hE400, 2'b00, 2'b00, 21'h005000, 1'b0);
    run(16'hD800, 2'b00, 2'b00, 21'h005000, 1'b0);
  endtask : t_other

  // Cycle ceiling against hangs
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // Main sequence
  initial
  begin
    fail_count = 0;
    checked    = 0;
    last       = 21'h000000;
    rst_i      = 1'b1;
    instr_i    = 16'h0000;
    pc_i       = 21'h000000;
    flags_i    = 2'b00;
    repeat (20) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(21'(phase_o), 21'(rbx_pkg::RBX_Q1));
    chk(21'(flush_o), 21'h000000);
    chk(21'(pcw_o.pc_we), 21'h000000);
    chk(pcw_o.pc_val, 21'h000000);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    t_bnofl();
    t_bnzero();
    t_balw();
    t_late();
    t_other();
    stop_test();
  end
endmodule : tb
